// >>> inc/serial_pkg.sv
// constants shared by both ends of the asynchronous serial link
// assumes a 25 MHz system clock on each end
// Functional notes
// - every bit lasts one equal bit period
// - start, data, parity if enabled, then stop
// - data field is 7 or 8 bits
// - rates 9600, 19200, 38400, 115200 selectable
// - odd parity makes total ones odd
// - even parity makes total ones even
// - configuration picks odd or even parity
// - parity catches single-bit errors, no correction
// - parity-failed frames are stored and flagged, not resent
// - both ends share identical frame settings
// - asynchronous only, resync on each start
// - separate lines, full duplex operation
// - rts/cts only on second serial port
// - handshake paces transfers when partner needs it
`default_nettype none
package serial_pkg;
  localparam int unsigned clk_hz = 25_000_000;
  localparam int unsigned rate_9600 = 9_600;
  localparam int unsigned rate_19200 = 19_200;
  localparam int unsigned rate_38400 = 38_400;
  localparam int unsigned rate_115200 = 115_200;
  localparam int div_w = 12;
  localparam logic [div_w-1:0] div_9600 = div_w'(clk_hz / rate_9600);
  localparam logic [div_w-1:0] div_19200 = div_w'(clk_hz / rate_19200);
  localparam logic [div_w-1:0] div_38400 = div_w'(clk_hz / rate_38400);
  localparam logic [div_w-1:0] div_115200 = div_w'(clk_hz / rate_115200);
  localparam logic [1:0] sel_9600 = 2'h0;
  localparam logic [1:0] sel_19200 = 2'h1;
  localparam logic [1:0] sel_38400 = 2'h2;
  localparam logic [1:0] sel_115200 = 2'h3;
  localparam logic line_mark = 1'h1;
  localparam logic line_space = 1'h0;
  localparam int data_w = 8;
  localparam logic [3:0] bits_short = 4'h7;
  localparam logic [3:0] bits_long = 4'h8;
  localparam int buf_depth = 2;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_start = 3'b001,
    st_data = 3'b010,
    st_parity = 3'b011,
    st_stop = 3'b100
  } frame_state_t;
  function automatic logic [div_w-1:0] rate_div(input logic [1:0] sel);
    logic [div_w-1:0] d;
    d = div_9600;
    case (sel)
      sel_19200: d = div_19200;
      sel_38400: d = div_38400;
      sel_115200: d = div_115200;
      default: d = div_9600;
    endcase
    return d;
  endfunction
endpackage
`default_nettype wire

// >>> inc/serial_link_if.sv
// link wires between the terminal and the controller
// assumes both ends share i_clk domain only for the bench
`timescale 1ns/100ps
`default_nettype none
interface serial_link_if;
  logic term_txd;
  logic plc_txd;
  logic term_rts;
  logic plc_cts;
  modport terminal (
    output term_txd,
    input plc_txd,
    output term_rts,
    input plc_cts
  );
  modport controller (
    input term_txd,
    output plc_txd,
    input term_rts,
    output plc_cts
  );
endinterface
`default_nettype wire

// >>> rtl/serial_engine.sv
// one full-duplex character engine: transmitter, receiver, two-entry buffer
// assumes the line input is asynchronous to i_clk
`timescale 1ns/100ps
`default_nettype none
module serial_engine #(
  parameter int width = serial_pkg::data_w,
  parameter int depth = serial_pkg::buf_depth
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [1:0] i_rate_sel,
  input wire logic i_eight_bits,
  input wire logic i_parity_en,
  input wire logic i_parity_odd,
  input wire logic i_flow_en,
  input wire logic [width-1:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic o_tx_busy,
  output logic [width-1:0] o_rx_data,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output logic o_rx_parity_err,
  input wire logic i_clr_parity_err,
  output logic o_rx_overrun,
  input wire logic i_rxd,
  output logic o_txd,
  input wire logic i_cts,
  output logic o_rts
);
  localparam int dw = serial_pkg::div_w;
  // tx state
  serial_pkg::frame_state_t tx_st_reg, tx_st_next;
  logic [dw-1:0] tx_cnt_reg, tx_cnt_next;
  logic [3:0] tx_bit_reg, tx_bit_next;
  logic [width-1:0] tx_sh_reg, tx_sh_next;
  logic tx_par_reg, tx_par_next;
  logic txd_reg, txd_next;
  logic [dw-1:0] div;
  logic [3:0] nbits;
  logic cts_ok;
  assign div = serial_pkg::rate_div(i_rate_sel);
  assign nbits = i_eight_bits ? serial_pkg::bits_long : serial_pkg::bits_short;
  // rx and cts line synchronisers
  logic [2:0] rxs_reg;
  logic rx_line_reg;
  logic [2:0] ctss_reg;
  logic cts_line_reg;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rxs_reg <= {3{serial_pkg::line_mark}};
      rx_line_reg <= serial_pkg::line_mark;
      ctss_reg <= 3'h0;
      cts_line_reg <= 1'h0;
    end else if (i_ce) begin
      rxs_reg <= {rxs_reg[1:0], i_rxd};
      ctss_reg <= {ctss_reg[1:0], i_cts};
      if (rxs_reg[1] == rxs_reg[2]) rx_line_reg <= rxs_reg[2];
      if (ctss_reg[1] == ctss_reg[2]) cts_line_reg <= ctss_reg[2];
    end
  end
  assign cts_ok = !i_flow_en || cts_line_reg;
  assign o_tx_ready = (tx_st_reg == serial_pkg::st_idle) && cts_ok;
  assign o_tx_busy = (tx_st_reg != serial_pkg::st_idle);
  assign o_txd = txd_reg;
  always_comb begin
    tx_st_next = tx_st_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_bit_next = tx_bit_reg;
    tx_sh_next = tx_sh_reg;
    tx_par_next = tx_par_reg;
    txd_next = txd_reg;
    if (tx_st_reg != serial_pkg::st_idle) tx_cnt_next = tx_cnt_reg - dw'(1);
    case (tx_st_reg)
      serial_pkg::st_idle: begin
        txd_next = serial_pkg::line_mark;
        if (i_tx_valid && cts_ok) begin
          tx_sh_next = i_tx_data;
          tx_par_next = i_parity_odd;
          tx_bit_next = 4'h0;
          tx_cnt_next = div - dw'(1);
          txd_next = serial_pkg::line_space;
          tx_st_next = serial_pkg::st_start;
        end
      end
      serial_pkg::st_start: begin
        if (tx_cnt_reg == '0) begin
          tx_cnt_next = div - dw'(1);
          txd_next = tx_sh_reg[0];
          tx_par_next = tx_par_reg ^ tx_sh_reg[0];
          tx_sh_next = tx_sh_reg >> 1;
          tx_st_next = serial_pkg::st_data;
        end
      end
      serial_pkg::st_data: begin
        if (tx_cnt_reg == '0) begin
          tx_cnt_next = div - dw'(1);
          tx_bit_next = tx_bit_reg + 4'h1;
          if (tx_bit_reg + 4'h1 == nbits) begin
            txd_next = i_parity_en ? tx_par_reg : serial_pkg::line_mark;
            tx_st_next = i_parity_en ? serial_pkg::st_parity : serial_pkg::st_stop;
          end else begin
            txd_next = tx_sh_reg[0];
            tx_par_next = tx_par_reg ^ tx_sh_reg[0];
            tx_sh_next = tx_sh_reg >> 1;
          end
        end
      end
      serial_pkg::st_parity: begin
        if (tx_cnt_reg == '0) begin
          tx_cnt_next = div - dw'(1);
          txd_next = serial_pkg::line_mark;
          tx_st_next = serial_pkg::st_stop;
        end
      end
      serial_pkg::st_stop: begin
        if (tx_cnt_reg == '0) tx_st_next = serial_pkg::st_idle;
      end
      default: tx_st_next = serial_pkg::st_idle;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_st_reg <= serial_pkg::st_idle;
      tx_cnt_reg <= '0;
      tx_bit_reg <= 4'h0;
      tx_sh_reg <= '0;
      tx_par_reg <= 1'h0;
      txd_reg <= serial_pkg::line_mark;
    end else if (i_ce) begin
      tx_st_reg <= tx_st_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bit_reg <= tx_bit_next;
      tx_sh_reg <= tx_sh_next;
      tx_par_reg <= tx_par_next;
      txd_reg <= txd_next;
    end
  end
  // receiver
  serial_pkg::frame_state_t rx_st_reg, rx_st_next;
  logic [dw-1:0] rx_cnt_reg, rx_cnt_next;
  logic [3:0] rx_bit_reg, rx_bit_next;
  logic [width-1:0] rx_sh_reg, rx_sh_next;
  logic rx_par_reg, rx_par_next;
  logic rx_push;
  logic rx_bad;
  always_comb begin
    rx_st_next = rx_st_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_bit_next = rx_bit_reg;
    rx_sh_next = rx_sh_reg;
    rx_par_next = rx_par_reg;
    rx_push = 1'b0;
    rx_bad = 1'b0;
    if (rx_st_reg != serial_pkg::st_idle) rx_cnt_next = rx_cnt_reg - dw'(1);
    case (rx_st_reg)
      serial_pkg::st_idle: begin
        if (rx_line_reg == serial_pkg::line_space) begin
          rx_cnt_next = (div >> 1) - dw'(1);
          rx_st_next = serial_pkg::st_start;
        end
      end
      serial_pkg::st_start: begin
        if (rx_cnt_reg == '0) begin
          rx_cnt_next = div - dw'(1);
          rx_bit_next = 4'h0;
          rx_par_next = i_parity_odd;
          rx_sh_next = '0;
          rx_st_next = (rx_line_reg == serial_pkg::line_space) ?
            serial_pkg::st_data : serial_pkg::st_idle;
        end
      end
      serial_pkg::st_data: begin
        if (rx_cnt_reg == '0) begin
          rx_cnt_next = div - dw'(1);
          rx_sh_next = rx_sh_reg | (width'(rx_line_reg) << rx_bit_reg);
          rx_par_next = rx_par_reg ^ rx_line_reg;
          rx_bit_next = rx_bit_reg + 4'h1;
          if (rx_bit_reg + 4'h1 == nbits)
            rx_st_next = i_parity_en ? serial_pkg::st_parity : serial_pkg::st_stop;
        end
      end
      serial_pkg::st_parity: begin
        if (rx_cnt_reg == '0) begin
          rx_cnt_next = div - dw'(1);
          rx_par_next = rx_par_reg ^ rx_line_reg;
          rx_st_next = serial_pkg::st_stop;
        end
      end
      serial_pkg::st_stop: begin
        if (rx_cnt_reg == '0) begin
          rx_st_next = serial_pkg::st_idle;
          rx_push = (rx_line_reg == serial_pkg::line_mark);
          rx_bad = i_parity_en && rx_par_reg;
        end
      end
      default: rx_st_next = serial_pkg::st_idle;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_st_reg <= serial_pkg::st_idle;
      rx_cnt_reg <= '0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= '0;
      rx_par_reg <= 1'h0;
    end else if (i_ce) begin
      rx_st_reg <= rx_st_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg <= rx_sh_next;
      rx_par_reg <= rx_par_next;
    end
  end
  // two-entry buffer, word plus parity tag
  logic [width:0] mem_reg [depth];
  logic [width:0] mem_next [depth];
  logic [1:0] cnt_reg, cnt_next;
  logic rd_ptr_reg, rd_ptr_next, wr_ptr_reg, wr_ptr_next;
  logic perr_reg, perr_next, ovr_reg, ovr_next;
  logic buf_ready, do_push, do_pop;
  assign buf_ready = (cnt_reg != 2'(depth));
  assign do_push = rx_push && buf_ready;
  assign do_pop = o_rx_valid && i_rx_ready;
  assign o_rx_valid = (cnt_reg != 2'h0);
  assign o_rx_data = mem_reg[rd_ptr_reg][width-1:0];
  assign o_rx_parity_err = perr_reg;
  assign o_rx_overrun = ovr_reg;
  assign o_rts = !i_flow_en || (cnt_reg == 2'h0);
  always_comb begin
    mem_next = mem_reg;
    cnt_next = cnt_reg;
    rd_ptr_next = rd_ptr_reg;
    wr_ptr_next = wr_ptr_reg;
    if (do_push) begin
      mem_next[wr_ptr_reg] = {rx_bad, rx_sh_reg};
      wr_ptr_next = !wr_ptr_reg;
    end
    if (do_pop) rd_ptr_next = !rd_ptr_reg;
    cnt_next = cnt_reg + 2'(do_push) - 2'(do_pop);
    // set wins over clear
    perr_next = (do_push && rx_bad) || (perr_reg && !i_clr_parity_err);
    ovr_next = (rx_push && !buf_ready) || (ovr_reg && !i_clr_parity_err);
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < depth; i++) mem_reg[i] <= '0;
      cnt_reg <= 2'h0;
      rd_ptr_reg <= 1'h0;
      wr_ptr_reg <= 1'h0;
      perr_reg <= 1'h0;
      ovr_reg <= 1'h0;
    end else if (i_ce) begin
      mem_reg <= mem_next;
      cnt_reg <= cnt_next;
      rd_ptr_reg <= rd_ptr_next;
      wr_ptr_reg <= wr_ptr_next;
      perr_reg <= perr_next;
      ovr_reg <= ovr_next;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/terminal_port.sv
// terminal end: first serial port plain, second with rts/cts pacing
// assumes the controller end shares frame settings
`timescale 1ns/100ps
`default_nettype none
module terminal_port (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_use_second_port,
  input wire logic i_flow_en,
  input wire logic [1:0] i_rate_sel,
  input wire logic i_eight_bits,
  input wire logic i_parity_en,
  input wire logic i_parity_odd,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic o_tx_busy,
  output logic [7:0] o_rx_data,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output logic o_rx_parity_err,
  input wire logic i_clr_parity_err,
  output logic o_rx_overrun,
  serial_link_if.terminal link
);
  logic flow;
  assign flow = i_use_second_port && i_flow_en;
  serial_engine u_eng (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_rate_sel(i_rate_sel),
    .i_eight_bits(i_eight_bits),
    .i_parity_en(i_parity_en),
    .i_parity_odd(i_parity_odd),
    .i_flow_en(flow),
    .i_tx_data(i_tx_data),
    .i_tx_valid(i_tx_valid),
    .o_tx_ready(o_tx_ready),
    .o_tx_busy(o_tx_busy),
    .o_rx_data(o_rx_data),
    .o_rx_valid(o_rx_valid),
    .i_rx_ready(i_rx_ready),
    .o_rx_parity_err(o_rx_parity_err),
    .i_clr_parity_err(i_clr_parity_err),
    .o_rx_overrun(o_rx_overrun),
    .i_rxd(link.plc_txd),
    .o_txd(link.term_txd),
    .i_cts(link.plc_cts),
    .o_rts(link.term_rts)
  );
endmodule
`default_nettype wire

// >>> rtl/controller_port.sv
// controller end of the link, same frame engine
// assumes identical settings to the terminal
`timescale 1ns/100ps
`default_nettype none
module controller_port (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_flow_en,
  input wire logic [1:0] i_rate_sel,
  input wire logic i_eight_bits,
  input wire logic i_parity_en,
  input wire logic i_parity_odd,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic o_tx_busy,
  output logic [7:0] o_rx_data,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output logic o_rx_parity_err,
  input wire logic i_clr_parity_err,
  output logic o_rx_overrun,
  serial_link_if.controller link
);
  serial_engine u_eng (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_rate_sel(i_rate_sel),
    .i_eight_bits(i_eight_bits),
    .i_parity_en(i_parity_en),
    .i_parity_odd(i_parity_odd),
    .i_flow_en(i_flow_en),
    .i_tx_data(i_tx_data),
    .i_tx_valid(i_tx_valid),
    .o_tx_ready(o_tx_ready),
    .o_tx_busy(o_tx_busy),
    .o_rx_data(o_rx_data),
    .o_rx_valid(o_rx_valid),
    .i_rx_ready(i_rx_ready),
    .o_rx_parity_err(o_rx_parity_err),
    .i_clr_parity_err(i_clr_parity_err),
    .o_rx_overrun(o_rx_overrun),
    .i_rxd(link.term_txd),
    .o_txd(link.plc_txd),
    .i_cts(link.term_rts),
    .o_rts(link.plc_cts)
  );
endmodule
`default_nettype wire

// >>> sim/serial_link_chk.sv
// checker for the framing seen on both wires of the serial link
// assumes both ends use the frame settings given on its inputs
`timescale 1ns/100ps
`default_nettype none
module serial_link_chk (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_rate_sel,
  input wire logic i_eight_bits,
  input wire logic i_parity_en,
  input wire logic i_parity_odd,
  input wire logic i_term_txd,
  input wire logic i_plc_txd,
  input wire logic i_term_rts,
  input wire logic i_plc_cts
);
  logic [1:0] line;
  logic [1:0] par;
  int fcnt [2];
  int dv;
  int flen;
  assign line = {i_plc_txd, i_term_txd};
  always_comb begin
    case (i_rate_sel)
      serial_pkg::sel_19200: dv = int'(serial_pkg::div_19200);
      serial_pkg::sel_38400: dv = int'(serial_pkg::div_38400);
      serial_pkg::sel_115200: dv = int'(serial_pkg::div_115200);
      default: dv = int'(serial_pkg::div_9600);
    endcase
    flen = (2 + (i_eight_bits ? 8 : 7) + (i_parity_en ? 1 : 0)) * dv;
  end
  // frame position and running parity of each line
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fcnt <= '{0, 0};
      par <= 2'h0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (fcnt[k] == 0) begin
          fcnt[k] <= line[k] ? 0 : 1;
          par[k] <= 1'b0;
        end else begin
          fcnt[k] <= (fcnt[k] == flen - 1) ? 0 : fcnt[k] + 1;
          if (fcnt[k] % dv == dv / 2 && fcnt[k] >= dv && fcnt[k] < flen - dv) begin
            par[k] <= par[k] ^ line[k];
          end
        end
      end
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  sequence s_in_start(int k);
    fcnt[k] != 0 && fcnt[k] < dv;
  endsequence
  sequence s_in_stop(int k);
    fcnt[k] >= flen - dv;
  endsequence
  property p_start(int k);
    s_in_start(k) |-> !line[k];
  endproperty
  property p_stop(int k);
    s_in_stop(k) |-> line[k];
  endproperty
  property p_steady(int k);
    fcnt[k] != 0 && fcnt[k] % dv != 0 |-> $stable(line[k]);
  endproperty
  property p_parity(int k);
    i_parity_en && fcnt[k] == flen - dv |-> par[k] == i_parity_odd;
  endproperty
  chk_start_term: assert property (p_start(0)) else $error("start bit not space");
  chk_start_plc: assert property (p_start(1)) else $error("start bit not space");
  chk_stop_term: assert property (p_stop(0)) else $error("stop bit not mark");
  chk_stop_plc: assert property (p_stop(1)) else $error("stop bit not mark");
  chk_bit_steady: assert property (p_steady(0)) else $error("bit changed mid period");
  chk_plc_steady: assert property (p_steady(1)) else $error("bit changed mid period");
  chk_parity_term: assert property (p_parity(0)) else $error("parity sum wrong");
  chk_parity_plc: assert property (p_parity(1)) else $error("parity sum wrong");
  chk_frame_gap: assert property (fcnt[0] == flen - 1 |=> line[0])
    else $error("no mark after frame");
  chk_reset_idle: assert property ($rose(i_rstn) |-> line == 2'h3 && i_term_rts && i_plc_cts)
    else $error("lines not idle after reset");
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// testbench joining both link ends through one interface
// assumes the checker beside the link watches the wire framing
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int limit = 95000;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic second = 1'b0;
  logic flow = 1'b0;
  logic [1:0] rate_sel = 2'h0;
  logic eight = 1'b0;
  logic pen = 1'b0;
  logic t_podd = 1'b0;
  logic c_podd = 1'b0;
  logic [7:0] tx_data [2] = '{8'h00, 8'h00};
  logic [1:0] tx_valid = 2'h0;
  logic [1:0] rx_ready = 2'h0;
  logic [1:0] clr = 2'h0;
  wire [1:0] tx_ready, busy, rx_valid, perr, ovr;
  wire [7:0] rx_data [2];
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  serial_link_if link ();
  terminal_port i_terminal_port (.i_clk, .i_rstn, .i_ce(1'b1), .i_use_second_port(second),
    .i_flow_en(flow), .i_rate_sel(rate_sel), .i_eight_bits(eight), .i_parity_en(pen),
    .i_parity_odd(t_podd), .i_tx_data(tx_data[0]), .i_tx_valid(tx_valid[0]),
    .o_tx_ready(tx_ready[0]), .o_tx_busy(busy[0]), .o_rx_data(rx_data[0]),
    .o_rx_valid(rx_valid[0]), .i_rx_ready(rx_ready[0]), .o_rx_parity_err(perr[0]),
    .i_clr_parity_err(clr[0]), .o_rx_overrun(ovr[0]), .link(link));
  controller_port i_controller_port (.i_clk, .i_rstn, .i_ce(1'b1), .i_flow_en(flow),
    .i_rate_sel(rate_sel), .i_eight_bits(eight), .i_parity_en(pen), .i_parity_odd(c_podd),
    .i_tx_data(tx_data[1]), .i_tx_valid(tx_valid[1]), .o_tx_ready(tx_ready[1]),
    .o_tx_busy(busy[1]), .o_rx_data(rx_data[1]), .o_rx_valid(rx_valid[1]),
    .i_rx_ready(rx_ready[1]), .o_rx_parity_err(perr[1]), .i_clr_parity_err(clr[1]),
    .o_rx_overrun(ovr[1]), .link(link));
  serial_link_chk i_serial_link_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_rate_sel(rate_sel),
    .i_eight_bits(eight), .i_parity_en(pen), .i_parity_odd(t_podd),
    .i_term_txd(link.term_txd), .i_plc_txd(link.plc_txd), .i_term_rts(link.term_rts),
    .i_plc_cts(link.plc_cts));
  always #20 i_clk = ~i_clk;
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == limit) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wait_idle();
    while (busy !== 2'h0) idle(1);
  endtask
  task automatic tx(input int e, input logic [7:0] d);
    tx_data[e] = d;
    tx_valid[e] = 1'b1;
    while (tx_ready[e] !== 1'b1) idle(1);
    idle(1);
    tx_valid[e] = 1'b0;
    check1(busy[e], 1'b1);
    idle(1);
  endtask
  task automatic wait_rx(input int e);
    while (rx_valid[e] !== 1'b1) idle(1);
  endtask
  task automatic rx(input int e, input logic [7:0] d);
    wait_rx(e);
    check8(rx_data[e], eight ? d : {1'b0, d[6:0]});
    rx_ready[e] = 1'b1;
    idle(1);
    rx_ready[e] = 1'b0;
    idle(1);
  endtask
  task automatic clear();
    clr = 2'h3;
    idle(1);
    clr = 2'h0;
  endtask
  task automatic xfer(input logic [7:0] d);
    fork
      tx(0, d);
      tx(1, ~d);
    join
    rx(1, d);
    rx(0, ~d);
    wait_idle();
    check1(perr[0], 1'b0);
    check1(perr[1], 1'b0);
  endtask
  initial begin
    idle(3);
    i_rstn = 1'b1;
    check1(link.term_txd, 1'b1);
    check1(link.plc_txd, 1'b1);
    check1(rx_valid[1], 1'b0);
    for (int r = 0; r < 4; r++) begin
      rate_sel = r[1:0];
      xfer(8'h45);
    end
    for (int m = 0; m < 8; m++) begin
      {eight, pen, t_podd} = m[2:0];
      c_podd = t_podd;
      xfer(8'h65 ^ 8'(m));
    end
    // opposite parity at the receiver flips one bit's meaning
    {eight, pen, t_podd, c_podd} = 4'he;
    tx(0, 8'h65);
    rx(1, 8'h65);
    check1(perr[1], 1'b1);
    c_podd = 1'b1;
    tx(0, 8'h61);
    rx(1, 8'h61);
    check1(perr[1], 1'b1);
    clear();
    check1(perr[1], 1'b0);
    // fill the two-entry buffer while the reader stalls
    for (int i = 0; i < 3; i++) tx(0, 8'h30 + 8'(i));
    wait_idle();
    check1(ovr[1], 1'b1);
    rx(1, 8'h30);
    rx(1, 8'h31);
    check1(rx_valid[1], 1'b0);
    clear();
    check1(ovr[1], 1'b0);
    second = 1'b1;
    flow = 1'b1;
    idle(8);
    tx(0, 8'h5a);
    wait_rx(1);
    wait_idle();
    idle(8);
    check1(tx_ready[0], 1'b0);
    rx(1, 8'h5a);
    idle(8);
    check1(tx_ready[0], 1'b1);
    second = 1'b0;
    tx(0, 8'h5b);
    wait_rx(1);
    wait_idle();
    idle(8);
    check1(tx_ready[0], 1'b1);
    rx(1, 8'h5b);
    report_and_stop();
  end
endmodule
`default_nettype wire
